// [logic/tmv_regs.vh]
`ifndef TMV_REGS_VH
`define TMV_REGS_VH

// ====================================================
// register byte offsets
`define TMV_OFF_FLAGS     8'h00
`define TMV_OFF_TRIG      8'h04
`define TMV_OFF_CTRL      8'h08
`define TMV_OFF_COUNT     8'h0C
`define TMV_OFF_CONST_A   8'h10
`define TMV_OFF_CONST_B   8'h14

// ====================================================
// flags / output select fields
`define TMV_BIT_MATCH_B   7
`define TMV_BIT_MATCH_A   6
`define TMV_BIT_WRAP      5
`define TMV_ACT_B_HI      3
`define TMV_ACT_B_LO      2
`define TMV_ACT_A_HI      1
`define TMV_ACT_A_LO      0
`define TMV_FLAGS_RSVD    8'h10

// ====================================================
// trigger / clock extra fields
`define TMV_EDGE_HI       4
`define TMV_EDGE_LO       3
`define TMV_BIT_TRIGGER_START_ENABLE      2
`define TMV_BIT_EXTRA     0
`define TMV_TRIG_RSVD     8'hE2

// ====================================================
// main control fields
`define TMV_BIT_IRQ_B     7
`define TMV_BIT_IRQ_A     6
`define TMV_BIT_IRQ_WRAP  5
`define TMV_CLR_HI        4
`define TMV_CLR_LO        3
`define TMV_PRE_HI        2
`define TMV_PRE_LO        0

// ====================================================
// codes and reset values
`define TMV_ACT_NONE      2'h0
`define TMV_ACT_LOW       2'h1
`define TMV_ACT_HIGH      2'h2
`define TMV_ACT_TOGGLE    2'h3
`define TMV_EDGE_OFF      2'h0
`define TMV_EDGE_RISE     2'h1
`define TMV_EDGE_FALL     2'h2
`define TMV_EDGE_BOTH     2'h3
`define TMV_CLR_NONE      2'h0
`define TMV_CLR_MATCH_A   2'h1
`define TMV_CLR_MATCH_B   2'h2
`define TMV_CLR_PIN       2'h3
`define TMV_RST_CONST     8'hFF
`define TMV_RST_BYTE      8'h00
`define TMV_CNT_MAX       8'hFF
`define TMV_CNT_ONE       8'h01
`define TMV_RESP_OKAY     2'h0
`define TMV_RESP_SLVERR   2'h2

`endif

// [logic/tmv_timer.v]
`include "tmv_regs.vh"

module tmv_timer #(
    parameter DIV_W = 7
) (
    input  wire        aclk,
    input  wire        aresetn,
    input  wire [7:0]  s_axi_awaddr,
    input  wire        s_axi_awvalid,
    output wire        s_axi_awready,
    input  wire [31:0] s_axi_wdata,
    input  wire [3:0]  s_axi_wstrb,
    input  wire        s_axi_wvalid,
    output wire        s_axi_wready,
    output reg  [1:0]  s_axi_bresp,
    output reg         s_axi_bvalid,
    input  wire        s_axi_bready,
    input  wire [7:0]  s_axi_araddr,
    input  wire        s_axi_arvalid,
    output wire        s_axi_arready,
    output reg  [31:0] s_axi_rdata,
    output reg  [1:0]  s_axi_rresp,
    output reg         s_axi_rvalid,
    input  wire        s_axi_rready,
    input  wire        trigger_in_pin,
    input  wire        external_clear_pin,
    input  wire        ext_clock_pin,
    output reg         waveform_out_pin,
    output reg         irq_request
);

    // ====================================================
    // register state
    reg [7:0]       up_counter_reg;
    reg [7:0]       constant_a_reg;
    reg [7:0]       constant_b_reg;
    reg [7:0]       timer_main_control_reg;
    reg [3:0]       out_select_reg;
    reg [1:0]       trigger_edge_sel_reg;
    reg             trigger_start_enable_reg;
    reg             extra_clock_select_reg;
    reg             match_a_flag_reg;
    reg             match_b_flag_reg;
    reg             overflow_flag_reg;
    reg [2:0]       armed_reg;
    reg             running_reg;
    reg [DIV_W-1:0] div_reg;
    reg [DIV_W-1:0] div_prev_reg;

    // ====================================================
    // pin synchronisers
    reg [1:0] trig_sync_reg;
    reg [1:0] clr_sync_reg;
    reg [1:0] ext_sync_reg;
    reg       trig_prev_reg;
    reg       clr_prev_reg;
    reg       ext_prev_reg;

    always @(posedge aclk) begin
        if (!aresetn) begin
            trig_sync_reg <= 2'h0;
            clr_sync_reg  <= 2'h0;
            ext_sync_reg  <= 2'h0;
            trig_prev_reg <= 1'b0;
            clr_prev_reg  <= 1'b0;
            ext_prev_reg  <= 1'b0;
        end else begin
            trig_sync_reg <= {trig_sync_reg[0], trigger_in_pin};
            clr_sync_reg  <= {clr_sync_reg[0], external_clear_pin};
            ext_sync_reg  <= {ext_sync_reg[0], ext_clock_pin};
            trig_prev_reg <= trig_sync_reg[1];
            clr_prev_reg  <= clr_sync_reg[1];
            ext_prev_reg  <= ext_sync_reg[1];
        end
    end

    wire trig_rise = trig_sync_reg[1] & ~trig_prev_reg;
    wire trig_fall = ~trig_sync_reg[1] & trig_prev_reg;
    wire clr_rise  = clr_sync_reg[1] & ~clr_prev_reg;
    wire ext_rise  = ext_sync_reg[1] & ~ext_prev_reg;
    wire ext_fall  = ~ext_sync_reg[1] & ext_prev_reg;

    // ====================================================
    // clock select and prescaler
    wire [2:0] pre_sel = timer_main_control_reg[`TMV_PRE_HI:`TMV_PRE_LO];
    reg        tick;
    reg [2:0]  tap_idx;

    always @* begin
        tick    = 1'b0;
        tap_idx = {pre_sel[1:0], extra_clock_select_reg} - 3'h1;
        if (!pre_sel[2]) begin
            // tap switching cannot fake a falling edge: both samples read the same tap
            if (pre_sel[1:0] != 2'h0)
                tick = div_prev_reg[tap_idx] & ~div_reg[tap_idx];
        end else begin
            case (pre_sel[1:0])
                2'h1:    tick = ext_rise;
                2'h2:    tick = ext_fall;
                2'h3:    tick = ext_rise | ext_fall;
                default: tick = 1'b0;
            endcase
        end
    end

    // ====================================================
    // trigger edge detection
    reg trig_edge;

    always @* begin
        case (trigger_edge_sel_reg)
            `TMV_EDGE_RISE: trig_edge = trig_rise;
            `TMV_EDGE_FALL: trig_edge = trig_fall;
            `TMV_EDGE_BOTH: trig_edge = trig_rise | trig_fall;
            default:        trig_edge = 1'b0;
        endcase
    end

    // ====================================================
    // compare, clear and count
    wire [1:0] clr_sel = timer_main_control_reg[`TMV_CLR_HI:`TMV_CLR_LO];
    wire       count_go = tick & (running_reg | ~trigger_start_enable_reg);
    // match fires on the last tick at which the values agree
    wire       match_a = count_go & (up_counter_reg == constant_a_reg);
    wire       match_b = count_go & (up_counter_reg == constant_b_reg);
    wire       wrap    = count_go & (up_counter_reg == `TMV_CNT_MAX);
    wire       clr_match = (clr_sel == `TMV_CLR_MATCH_A && match_a) ||
                           (clr_sel == `TMV_CLR_MATCH_B && match_b);
    wire       clr_pin   = (clr_sel == `TMV_CLR_PIN) && clr_rise;

    // ====================================================
    // waveform output action
    wire [1:0] act_a = match_a ? out_select_reg[`TMV_ACT_A_HI:`TMV_ACT_A_LO] : `TMV_ACT_NONE;
    wire [1:0] act_b = match_b ? out_select_reg[`TMV_ACT_B_HI:`TMV_ACT_B_LO] : `TMV_ACT_NONE;
    reg        wave_next;

    always @* begin
        wave_next = waveform_out_pin;
        if (act_a == `TMV_ACT_TOGGLE || act_b == `TMV_ACT_TOGGLE)
            wave_next = ~waveform_out_pin;
        else if (act_a == `TMV_ACT_HIGH || act_b == `TMV_ACT_HIGH)
            wave_next = 1'b1;
        else if (act_a == `TMV_ACT_LOW || act_b == `TMV_ACT_LOW)
            wave_next = 1'b0;
    end

    // ====================================================
    // AXI4-Lite write channel
    reg        aw_got_reg;
    reg        w_got_reg;
    reg [7:0]  aw_addr_reg;
    reg [7:0]  w_byte_reg;
    reg        w_lane_reg;

    assign s_axi_awready = ~aw_got_reg & ~s_axi_bvalid;
    assign s_axi_wready  = ~w_got_reg & ~s_axi_bvalid;

    wire do_write = aw_got_reg & w_got_reg & ~s_axi_bvalid;
    wire wr_ok    = do_write & w_lane_reg;
    wire wr_flags = wr_ok && aw_addr_reg == `TMV_OFF_FLAGS;
    wire wr_trig  = wr_ok && aw_addr_reg == `TMV_OFF_TRIG;
    wire wr_ctrl  = wr_ok && aw_addr_reg == `TMV_OFF_CTRL;
    wire wr_count = wr_ok && aw_addr_reg == `TMV_OFF_COUNT;
    wire wr_ca    = wr_ok && aw_addr_reg == `TMV_OFF_CONST_A;
    wire wr_cb    = wr_ok && aw_addr_reg == `TMV_OFF_CONST_B;
    reg  aw_mapped;

    always @* begin
        if (aw_addr_reg == `TMV_OFF_FLAGS || aw_addr_reg == `TMV_OFF_TRIG)
            aw_mapped = 1'b1;
        else if (aw_addr_reg == `TMV_OFF_CTRL || aw_addr_reg == `TMV_OFF_COUNT)
            aw_mapped = 1'b1;
        else if (aw_addr_reg == `TMV_OFF_CONST_A || aw_addr_reg == `TMV_OFF_CONST_B)
            aw_mapped = 1'b1;
        else
            aw_mapped = 1'b0;
    end

    always @(posedge aclk) begin
        if (!aresetn) begin
            aw_got_reg   <= 1'b0;
            w_got_reg    <= 1'b0;
            aw_addr_reg  <= 8'h00;
            w_byte_reg   <= 8'h00;
            w_lane_reg   <= 1'b0;
            s_axi_bvalid <= 1'b0;
            s_axi_bresp  <= `TMV_RESP_OKAY;
        end else begin
            if (s_axi_awvalid && s_axi_awready) begin
                aw_got_reg  <= 1'b1;
                aw_addr_reg <= {s_axi_awaddr[7:2], 2'h0};
            end
            if (s_axi_wvalid && s_axi_wready) begin
                w_got_reg  <= 1'b1;
                w_byte_reg <= s_axi_wdata[7:0];
                w_lane_reg <= s_axi_wstrb[0];
            end
            if (do_write) begin
                aw_got_reg   <= 1'b0;
                w_got_reg    <= 1'b0;
                s_axi_bvalid <= 1'b1;
                s_axi_bresp  <= aw_mapped ? `TMV_RESP_OKAY : `TMV_RESP_SLVERR;
            end else if (s_axi_bvalid && s_axi_bready) begin
                s_axi_bvalid <= 1'b0;
            end
        end
    end

    // ====================================================
    // AXI4-Lite read channel
    wire [7:0] flags_view = {match_b_flag_reg, match_a_flag_reg, overflow_flag_reg,
                             1'b0, out_select_reg} | `TMV_FLAGS_RSVD;
    wire [7:0] trig_view  = {3'h0, trigger_edge_sel_reg, trigger_start_enable_reg,
                             1'b0, extra_clock_select_reg} | `TMV_TRIG_RSVD;
    wire       rd_take    = s_axi_arvalid & s_axi_arready;
    wire [7:0] ar_addr    = {s_axi_araddr[7:2], 2'h0};
    wire       rd_flags   = rd_take && ar_addr == `TMV_OFF_FLAGS;
    reg  [7:0] rd_byte;
    reg        rd_err;

    assign s_axi_arready = ~s_axi_rvalid;

    always @* begin
        rd_byte = 8'h00;
        rd_err  = 1'b0;
        if (ar_addr == `TMV_OFF_FLAGS)
            rd_byte = flags_view;
        else if (ar_addr == `TMV_OFF_TRIG)
            rd_byte = trig_view;
        else if (ar_addr == `TMV_OFF_CTRL)
            rd_byte = timer_main_control_reg;
        else if (ar_addr == `TMV_OFF_COUNT)
            rd_byte = up_counter_reg;
        else if (ar_addr == `TMV_OFF_CONST_A)
            rd_byte = constant_a_reg;
        else if (ar_addr == `TMV_OFF_CONST_B)
            rd_byte = constant_b_reg;
        else
            rd_err = 1'b1;
    end

    always @(posedge aclk) begin
        if (!aresetn) begin
            s_axi_rvalid <= 1'b0;
            s_axi_rdata  <= 32'h0000_0000;
            s_axi_rresp  <= `TMV_RESP_OKAY;
        end else if (rd_take) begin
            s_axi_rvalid <= 1'b1;
            s_axi_rdata  <= {24'h00_0000, rd_byte};
            s_axi_rresp  <= rd_err ? `TMV_RESP_SLVERR : `TMV_RESP_OKAY;
        end else if (s_axi_rready) begin
            s_axi_rvalid <= 1'b0;
        end
    end

    // ====================================================
    // flags with read-then-write-zero clearing
    wire [2:0] flag_now = {match_b_flag_reg, match_a_flag_reg, overflow_flag_reg};
    wire [2:0] flag_set = {match_b, match_a, wrap};
    wire [2:0] wr_bits  = {w_byte_reg[`TMV_BIT_MATCH_B], w_byte_reg[`TMV_BIT_MATCH_A],
                           w_byte_reg[`TMV_BIT_WRAP]};
    // a 1 written keeps the flag, a 0 only clears when armed by a read
    wire [2:0] flag_clr = wr_flags ? (armed_reg & ~wr_bits) : 3'h0;
    wire [2:0] flag_next = flag_set | (flag_now & ~flag_clr);

    always @(posedge aclk) begin
        if (!aresetn) begin
            match_b_flag_reg  <= 1'b0;
            match_a_flag_reg  <= 1'b0;
            overflow_flag_reg <= 1'b0;
            armed_reg         <= 3'h0;
        end else begin
            match_b_flag_reg  <= flag_next[2];
            match_a_flag_reg  <= flag_next[1];
            overflow_flag_reg <= flag_next[0];
            // arm on a read returning 1; the write consumes the arming
            if (rd_flags)
                armed_reg <= (wr_flags ? 3'h0 : armed_reg) | flag_now;
            else if (wr_flags)
                armed_reg <= 3'h0;
        end
    end

    // ====================================================
    // control registers, counter, run state, output
    always @(posedge aclk) begin
        if (!aresetn) begin
            up_counter_reg           <= `TMV_RST_BYTE;
            constant_a_reg           <= `TMV_RST_CONST;
            constant_b_reg           <= `TMV_RST_CONST;
            timer_main_control_reg   <= `TMV_RST_BYTE;
            out_select_reg           <= 4'h0;
            trigger_edge_sel_reg     <= `TMV_EDGE_OFF;
            trigger_start_enable_reg <= 1'b0;
            extra_clock_select_reg   <= 1'b0;
            running_reg              <= 1'b1;
            waveform_out_pin         <= 1'b0;
            irq_request              <= 1'b0;
            div_reg                  <= {DIV_W{1'b0}};
            div_prev_reg             <= {DIV_W{1'b0}};
        end else begin
            div_reg      <= div_reg + {{(DIV_W-1){1'b0}}, 1'b1};
            div_prev_reg <= div_reg;
            if (wr_flags)
                out_select_reg <= w_byte_reg[`TMV_ACT_B_HI:`TMV_ACT_A_LO];
            if (wr_trig) begin
                trigger_edge_sel_reg     <= w_byte_reg[`TMV_EDGE_HI:`TMV_EDGE_LO];
                trigger_start_enable_reg <= w_byte_reg[`TMV_BIT_TRIGGER_START_ENABLE];
                extra_clock_select_reg   <= w_byte_reg[`TMV_BIT_EXTRA];
            end
            if (wr_ctrl)
                timer_main_control_reg <= w_byte_reg;
            if (wr_ca)
                constant_a_reg <= w_byte_reg;
            if (wr_cb)
                constant_b_reg <= w_byte_reg;
            // clear beats a software write, a write beats counting
            if (clr_match || clr_pin)
                up_counter_reg <= `TMV_RST_BYTE;
            else if (wr_count)
                up_counter_reg <= w_byte_reg;
            else if (count_go)
                up_counter_reg <= up_counter_reg + `TMV_CNT_ONE;
            if (!trigger_start_enable_reg)
                running_reg <= 1'b1;
            else if (trig_edge)
                running_reg <= 1'b1;
            else if (clr_match || clr_pin)
                running_reg <= 1'b0;
            waveform_out_pin <= wave_next;
            irq_request <= (flag_next[2] & timer_main_control_reg[`TMV_BIT_IRQ_B]) |
                           (flag_next[1] & timer_main_control_reg[`TMV_BIT_IRQ_A]) |
                           (flag_next[0] & timer_main_control_reg[`TMV_BIT_IRQ_WRAP]);
        end
    end

endmodule

// [tb/tmv_timer_props.sv]
// ========
// port-level checks on the timer status block
module tmv_timer_props (
    input wire        aclk,
    input wire        aresetn,
    input wire [7:0]  s_axi_awaddr,
    input wire        s_axi_awvalid,
    input wire        s_axi_awready,
    input wire [1:0]  s_axi_bresp,
    input wire        s_axi_bvalid,
    input wire        s_axi_bready,
    input wire        s_axi_arvalid,
    input wire [7:0]  s_axi_araddr,
    input wire        s_axi_arready,
    input wire [31:0] s_axi_rdata,
    input wire        s_axi_rvalid,
    input wire        s_axi_rready,
    input wire        waveform_out_pin
);
    timeunit 1ns;
    timeprecision 1ns;
    reg  [7:0] ar_reg;
    reg  [7:0] aw_reg;
    reg  [2:0] flags_reg;
    reg        snap_ok_reg;
    wire       rd_flags = s_axi_rvalid && ar_reg[7:2] == 6'h00;
    wire       rd_trig  = s_axi_rvalid && ar_reg[7:2] == 6'h01;
    // a flags write in flight voids the snapshot
    always @(posedge aclk) begin
        if (!aresetn) begin
            ar_reg      <= 8'h00;
            aw_reg      <= 8'h00;
            flags_reg   <= 3'h0;
            snap_ok_reg <= 1'b0;
        end else begin
            if (s_axi_arvalid && s_axi_arready) ar_reg <= s_axi_araddr;
            if (s_axi_awvalid && s_axi_awready) aw_reg <= s_axi_awaddr;
            if (rd_flags && s_axi_rready) begin
                flags_reg   <= s_axi_rdata[7:5];
                snap_ok_reg <= 1'b1;
            end
            if ((s_axi_awvalid && s_axi_awaddr[7:2] == 6'h00) || (s_axi_bvalid && aw_reg[7:2] == 6'h00))
                snap_ok_reg <= 1'b0;
        end
    end
    // ========
    // assertions and cover points
    default clocking cb @(posedge aclk); endclocking
    default disable iff (!aresetn);
    chk_wave_at_start: assert property ($rose(aresetn) |-> !waveform_out_pin)
        else $error("waveform output not low after reset");
    chk_flags_rsvd_one: assert property (rd_flags |-> s_axi_rdata[4])
        else $error("flags reserved bit read as 0");
    chk_trig_rsvd_one: assert property (rd_trig |-> s_axi_rdata[7:5] == 3'h7 && s_axi_rdata[1])
        else $error("trigger reserved bits read as 0");
    chk_flag_sticky: assert property (rd_flags && s_axi_rready && snap_ok_reg |->
        (s_axi_rdata[7:5] & flags_reg) == flags_reg)
        else $error("status flag dropped without a clearing write");
    chk_rd_answer: assert property (s_axi_arvalid && s_axi_arready |=> s_axi_rvalid)
        else $error("read answer late");
    chk_rd_hold: assert property (s_axi_rvalid && !s_axi_rready |=> s_axi_rvalid && $stable(s_axi_rdata))
        else $error("read answer not held");
    chk_wr_hold: assert property (s_axi_bvalid && !s_axi_bready |=> s_axi_bvalid && $stable(s_axi_bresp))
        else $error("write answer not held");
    chk_bad_addr_err: assert property ($rose(s_axi_bvalid) && aw_reg > 8'h17 |-> s_axi_bresp == 2'h2)
        else $error("unmapped write not refused");
    cov_bad_addr: cover property (s_axi_bvalid && s_axi_bresp == 2'h2);
    cov_wave_rise: cover property ($rose(waveform_out_pin));
    cov_wrap_seen: cover property (rd_flags && s_axi_rdata[5]);
endmodule

bind tmv_timer tmv_timer_props u_tmv_timer_props (
    .aclk, .aresetn, .s_axi_awaddr, .s_axi_awvalid, .s_axi_awready, .s_axi_bresp, .s_axi_bvalid, .s_axi_bready,
    .s_axi_arvalid, .s_axi_araddr, .s_axi_arready, .s_axi_rdata, .s_axi_rvalid, .s_axi_rready, .waveform_out_pin
);

// [tb/tmv_trig_src.sv]
// ========
// far side: trigger source, clear source and external count clock
module tmv_trig_src (
    input  wire aclk,
    output reg  trigger_in_pin,
    output reg  external_clear_pin,
    output reg  ext_clock_pin
);
    timeunit 1ns;
    timeprecision 1ns;
    initial begin
        trigger_in_pin     = 1'b0;
        external_clear_pin = 1'b0;
        ext_clock_pin      = 1'b0;
    end
    task automatic set_trigger(input logic lv);
        trigger_in_pin <= lv;
        @(posedge aclk);
    endtask
    // four clocks high, past the minimum width
    task automatic pulse_clear();
        external_clear_pin <= 1'b1;
        repeat (4) @(posedge aclk);
        external_clear_pin <= 1'b0;
        @(posedge aclk);
    endtask
    // count clock stands low between bursts
    task automatic ext_pulses(input int n);
        repeat (n) begin
            ext_clock_pin <= 1'b1;
            repeat (4) @(posedge aclk);
            ext_clock_pin <= 1'b0;
            repeat (4) @(posedge aclk);
        end
    endtask
endmodule

// [tb/tmv_timer_tb_top.sv]
module tmv_timer_tb_top;
    timeunit 1ns;
    timeprecision 1ns;
    logic        aclk, aresetn, s_axi_awvalid, s_axi_wvalid, s_axi_bready, s_axi_arvalid, s_axi_rready;
    logic [7:0]  s_axi_awaddr, s_axi_araddr;
    logic [31:0] s_axi_wdata;
    logic [3:0]  s_axi_wstrb;
    wire         s_axi_awready, s_axi_wready, s_axi_bvalid, s_axi_arready, s_axi_rvalid;
    wire  [1:0]  s_axi_bresp, s_axi_rresp;
    wire  [31:0] s_axi_rdata;
    wire         trigger_in_pin, external_clear_pin, ext_clock_pin, waveform_out_pin, irq_request;
    int          failures;
    int          checks_done;

    tmv_timer u_tmv_timer (
        .aclk, .aresetn, .s_axi_awaddr, .s_axi_awvalid, .s_axi_awready, .s_axi_wdata, .s_axi_wstrb, .s_axi_wvalid,
        .s_axi_wready, .s_axi_bresp, .s_axi_bvalid, .s_axi_bready, .s_axi_araddr, .s_axi_arvalid, .s_axi_arready,
        .s_axi_rdata, .s_axi_rresp, .s_axi_rvalid, .s_axi_rready, .trigger_in_pin, .external_clear_pin,
        .ext_clock_pin, .waveform_out_pin, .irq_request
    );
    tmv_trig_src u_tmv_trig_src (
        .aclk, .trigger_in_pin, .external_clear_pin, .ext_clock_pin
    );

    // ========
    // reporting
    task automatic print_verdict();
        if (failures == 0 && checks_done > 0) begin
            $display("*** PASS ***");
        end else begin
            $display("*** FAIL ***");
        end
        $finish;
    endtask
    task automatic timeout();
        failures++;
        print_verdict();
    endtask
    task automatic check_byte(input string what, input logic [7:0] exp, input logic [7:0] got);
        checks_done++;
        if (got !== exp) begin
            failures++;
            $display("wrong value %s expected %h seen %h", what, exp, got);
        end
    endtask
    task automatic check_bit(input string what, input logic exp, input logic got);
        checks_done++;
        if (got !== exp) begin
            failures++;
            $display("wrong value %s expected %b seen %b", what, exp, got);
        end
    endtask
    task automatic check_near(input string what, input int exp, input int tol, input logic [7:0] got);
        checks_done++;
        if ($isunknown(got) || got < exp - tol || got > exp + tol) begin
            failures++;
            $display("wrong value %s expected %0d seen %0d", what, exp, got);
        end
    endtask

    // ========
    // register bus master
    task automatic bus_write(input logic [7:0] a, input logic [7:0] d, output logic [1:0] resp);
        int n;
        n = 0;
        s_axi_awaddr  <= a;
        s_axi_awvalid <= 1'b1;
        s_axi_wdata   <= {24'h00_0000, d};
        s_axi_wvalid  <= 1'b1;
        s_axi_bready  <= 1'b1;
        do begin
            @(posedge aclk);
            n++;
            if (s_axi_awready) s_axi_awvalid <= 1'b0;
            if (s_axi_wready) s_axi_wvalid <= 1'b0;
        end while (!s_axi_bvalid && n < 100);
        resp = s_axi_bresp;
        s_axi_bready <= 1'b0;
        @(posedge aclk);
        if (n >= 100) timeout();
    endtask
    task automatic bus_read(input logic [7:0] a, output logic [7:0] d);
        int n;
        n = 0;
        s_axi_araddr  <= a;
        s_axi_arvalid <= 1'b1;
        s_axi_rready  <= 1'b1;
        do begin
            @(posedge aclk);
            n++;
            if (s_axi_arready) s_axi_arvalid <= 1'b0;
        end while (!s_axi_rvalid && n < 100);
        d = s_axi_rdata[7:0];
        check_byte("read resp", {6'h00, a > 8'h17, 1'b0}, {6'h00, s_axi_rresp});
        s_axi_rready <= 1'b0;
        @(posedge aclk);
        if (n >= 100) timeout();
    endtask
    task automatic wr(input logic [7:0] a, input logic [7:0] d);
        logic [1:0] r;
        bus_write(a, d, r);
    endtask
    task automatic rd_chk(input logic [7:0] a, input logic [7:0] exp, input string what);
        logic [7:0] v;
        bus_read(a, v);
        check_byte(what, exp, v);
    endtask
    task automatic wave_changes(input int lim, output logic seen);
        logic w0;
        w0 = waveform_out_pin;
        seen = 1'b0;
        for (int n = 0; n < lim && !seen; n++) begin
            @(posedge aclk);
            seen = waveform_out_pin !== w0;
        end
    endtask

    // ========
    // scenarios
    task automatic test_reset_values();
        logic [1:0] r;
        check_bit("wave after reset", 1'b0, waveform_out_pin);
        rd_chk(8'h00, 8'h10, "flags at reset");
        rd_chk(8'h04, 8'hE2, "trig at reset");
        wr(8'h04, 8'h1D);
        rd_chk(8'h04, 8'hFF, "trig all set");
        wr(8'h04, 8'h00);
        rd_chk(8'h04, 8'hE2, "trig reserved");
        wr(8'h00, 8'hEF);
        rd_chk(8'h00, 8'h1F, "flags no soft set");
        bus_write(8'h18, 8'h01, r);
        check_byte("unmapped resp", 8'h02, {6'h00, r});
        rd_chk(8'h18, 8'h00, "unmapped read");
    endtask
    task automatic test_match_a();
        logic seen;
        wr(8'h10, 8'h05);
        wr(8'h00, 8'h02);
        wr(8'h08, 8'h01);
        wave_changes(200, seen);
        check_bit("wave driven high", 1'b1, waveform_out_pin);
        wr(8'h08, 8'h00);
        wr(8'h00, 8'h02);
        rd_chk(8'h00, 8'h52, "match a kept");
        wr(8'h00, 8'h02);
        rd_chk(8'h00, 8'h12, "match a cleared");
    endtask
    task automatic test_wrap();
        wr(8'h00, 8'h00);
        wr(8'h10, 8'hFF);
        wr(8'h0C, 8'hFE);
        wr(8'h08, 8'h01);
        repeat (12) @(posedge aclk);
        wr(8'h08, 8'hE0);
        check_bit("irq on", 1'b1, irq_request);
        wr(8'h00, 8'h00);
        rd_chk(8'h00, 8'hF0, "unread kept");
        wr(8'h00, 8'hC0);
        rd_chk(8'h00, 8'hD0, "wrap cleared");
        wr(8'h00, 8'h00);
        rd_chk(8'h00, 8'h10, "all cleared");
        check_bit("irq off", 1'b0, irq_request);
    endtask
    // other side gets the opposite action, so a stray match on it shows
    task automatic test_actions(input int sh);
        logic [1:0] seq [4] = '{2'h2, 2'h1, 2'h3, 2'h0};
        logic       seen;
        wr(8'h0C, 8'h00);
        wr(sh ? 8'h10 : 8'h14, 8'hFF);
        wr(sh ? 8'h14 : 8'h10, 8'h03);
        wr(8'h08, sh ? 8'h11 : 8'h09);
        foreach (seq[i]) begin
            wr(8'h00, ({6'h00, seq[i]} << sh) | ({6'h00, ~seq[i]} << (2 - sh)));
            wave_changes(40, seen);
            if (seq[i] == 2'h3) begin
                check_bit("wave toggles", 1'b1, seen);
                wave_changes(40, seen);
                check_bit("wave toggles again", 1'b1, seen);
            end else if (seq[i] == 2'h0) begin
                check_bit("wave kept", 1'b0, seen);
            end else begin
                check_bit("wave level", seq[i] == 2'h2, waveform_out_pin);
            end
        end
        wr(8'h08, 8'h00);
    endtask
    task automatic test_trigger();
        logic seen;
        wr(8'h00, 8'h03);
        wr(8'h10, 8'h03);
        wr(8'h14, 8'hFF);
        wr(8'h08, 8'h09);
        for (int c = 0; c < 4; c++) begin
            wr(8'h04, 8'(c << 3) | 8'h04);
            repeat (40) @(posedge aclk);
            for (int lv = 1; lv >= 0; lv--) begin
                u_tmv_trig_src.set_trigger(lv[0]);
                wave_changes(40, seen);
                check_bit("trigger restart", c == 3 || c == 2 - lv, seen);
            end
        end
        wr(8'h04, 8'h08);
        wave_changes(40, seen);
        wave_changes(40, seen);
        check_bit("free run", 1'b1, seen);
        wr(8'h08, 8'h00);
    endtask
    task automatic test_clock_sel();
        logic [7:0] ctl [9] = '{8'h01, 8'h01, 8'h02, 8'h03, 8'h00, 8'h04, 8'h05, 8'h06, 8'h07};
        int         ext [9] = '{0, 1, 0, 1, 0, 0, 0, 0, 0};
        int         exp [9] = '{64, 32, 16, 2, 0, 0, 5, 5, 10};
        logic [7:0] v;
        foreach (ctl[i]) begin
            wr(8'h0C, 8'h00);
            wr(8'h04, 8'(ext[i]));
            wr(8'h08, ctl[i]);
            if (ctl[i][2]) u_tmv_trig_src.ext_pulses(5);
            else repeat (256) @(posedge aclk);
            repeat (4) @(posedge aclk);
            wr(8'h08, 8'h00);
            bus_read(8'h0C, v);
            check_near("count", exp[i], ctl[i][2] ? 0 : exp[i] / 16 + (exp[i] > 0), v);
        end
        wr(8'h0C, 8'h80);
        wr(8'h08, 8'h18);
        u_tmv_trig_src.pulse_clear();
        repeat (4) @(posedge aclk);
        rd_chk(8'h0C, 8'h00, "pin clear");
    endtask

    initial begin
        aclk = 1'b0;
        forever #50 aclk = ~aclk;
    end
    initial begin
        repeat (100000) @(posedge aclk);
        timeout();
    end
    initial begin
        failures = 0;
        checks_done = 0;
        aresetn = 1'b0;
        {s_axi_awvalid, s_axi_wvalid, s_axi_bready, s_axi_arvalid, s_axi_rready} = 5'h00;
        s_axi_awaddr = 8'h00;
        s_axi_araddr = 8'h00;
        s_axi_wdata = 32'h0000_0000;
        s_axi_wstrb = 4'hF;
        repeat (5) @(posedge aclk);
        aresetn <= 1'b1;
        @(posedge aclk);
        test_reset_values();
        test_match_a();
        test_wrap();
        test_actions(0);
        test_actions(2);
        test_trigger();
        test_clock_sel();
        print_verdict();
    end
endmodule
